// ### sac_defs.vh
// Contract
// - converter clock is peripheral clock over divider
// - divider value zero divides by thirty-two
// - select 0 picks second input, 1 first
// - freeze bit halts cpu during conversion
// - hardware clears freeze bit at conversion end
// - only cpu frozen, peripherals keep running
// - interrupts held during freeze, serviced afterwards
// - enable powers converter, clear means standby
// - start bit reads set until conversion ends
// - result ready eleven converter clocks after start
// - done flag sets and start bit clears
// - done flag requests irq, software clears
// - high byte holds eight upper result bits
// - low byte holds two lsbs, rest zero
// - reserved control and divider bits read zero
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH

// ****************************************
// register addresses
// ****************************************
`define SAC_ADDR_DIV     8'hf2
`define SAC_ADDR_CTRL    8'hf3
`define SAC_ADDR_RES_LO  8'hf4
`define SAC_ADDR_RES_HI  8'hf5

// ****************************************
// control register fields
// ****************************************
`define SAC_CTRL_FREEZE  6
`define SAC_CTRL_ENABLE  5
`define SAC_CTRL_DONE    4
`define SAC_CTRL_START   3
`define SAC_CTRL_CHSEL   0
`define SAC_CTRL_RST     8'h00
`define SAC_DIV_RST      8'h00
`define SAC_DIV_W        5

// ****************************************
// timing
// ****************************************
`define SAC_CONV_CLKS    4'hb
`define SAC_DIV_ZERO_AS  6'h20

`endif

// ### sac_clk_div.v
`timescale 1ns/100ps
`include "sac_defs.vh"
// one-cycle tick every divider_value peripheral clocks, every thirty-two when divider_value is zero
module sac_clk_div #(
    parameter DW = `SAC_DIV_W
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          run_i,
    input  wire [DW-1:0] divider_value_i,
    output reg           tick_o
);
    reg  [DW:0] cnt_q;
    wire [DW:0] limit;

    assign limit = (divider_value_i == {DW{1'b0}}) ? `SAC_DIV_ZERO_AS : {1'b0, divider_value_i};

    always @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_q  <= {(DW+1){1'b0}};
            tick_o <= 1'b0;
        end else if (cnt_q + 1'b1 >= limit) begin
            cnt_q  <= {(DW+1){1'b0}};
            tick_o <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule // sac_clk_div

// ### sac_conv_ctrl.v
`timescale 1ns/100ps
`include "sac_defs.vh"
module sac_conv_ctrl #(
    parameter RES_W = 10
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [7:0]       sfr_addr_i,
    input  wire             sfr_wr_i,
    input  wire [7:0]       sfr_wdata_i,
    input  wire             sfr_rd_i,
    output reg  [7:0]       sfr_rdata_o,
    input  wire             irq_en_i,
    input  wire [RES_W-1:0] afe_result_i,
    output reg              afe_power_o,
    output reg              afe_sel_first_o,
    output reg              afe_sample_o,
    output reg              cpu_freeze_o,
    output reg              irq_o
);

    // ****************************************
    // constants
    // ****************************************
    localparam       ST_IDLE  = 1'b0;
    localparam       ST_CONV  = 1'b1;
    localparam       DW       = `SAC_DIV_W;
    localparam       LO_W     = 2;
    localparam       HI_W     = 8;
    localparam [7:0] CTRL_RST = `SAC_CTRL_RST;
    localparam [7:0] DIV_RST  = `SAC_DIV_RST;
    // last tick index of a conversion
    localparam [3:0] LAST_CYC = `SAC_CONV_CLKS - 4'h1;

    // ****************************************
    // state and register storage
    // ****************************************
    reg              st_q;
    reg              st_d;
    reg  [3:0]       cyc_q;
    reg  [3:0]       cyc_d;
    reg              freeze_q;
    reg              freeze_d;
    reg              enable_q;
    reg              enable_d;
    reg              done_q;
    reg              done_d;
    reg              chsel_q;
    reg              chsel_d;
    reg  [DW-1:0]    div_q;
    reg  [DW-1:0]    div_d;
    reg  [RES_W-1:0] res_q;
    reg  [RES_W-1:0] res_d;

    // ****************************************
    // next values of the registered outputs
    // ****************************************
    reg  [7:0]       rdata_d;
    reg              power_d;
    reg              sel_first_d;
    reg              sample_d;
    reg              cpu_freeze_d;
    reg              irq_d;

    // ****************************************
    // decoded strobes and readback words
    // ****************************************
    wire             tick;
    wire             busy;
    wire             wr_div;
    wire             wr_ctrl;
    wire             start_req;
    wire             finish;
    wire [7:0]       ctrl_rd;
    wire [7:0]       div_rd;
    wire [7:0]       res_lo_byte;
    wire [7:0]       res_hi_byte;

    // ****************************************
    // helper functions
    // ****************************************
    // one compare shared by write strobes and read mux
    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    function [7:0] ctrl_pack;
        input freeze;
        input enable;
        input done;
        input start;
        input chsel;
        begin
            ctrl_pack                   = 8'h00;
            ctrl_pack[`SAC_CTRL_FREEZE] = freeze;
            ctrl_pack[`SAC_CTRL_ENABLE] = enable;
            ctrl_pack[`SAC_CTRL_DONE]   = done;
            ctrl_pack[`SAC_CTRL_START]  = start;
            ctrl_pack[`SAC_CTRL_CHSEL]  = chsel;
        end
    endfunction

    // ****************************************
    // bus decode
    // ****************************************
    assign busy      = (st_q == ST_CONV);
    assign wr_div    = sfr_wr_i && addr_hit(sfr_addr_i, `SAC_ADDR_DIV);
    assign wr_ctrl   = sfr_wr_i && addr_hit(sfr_addr_i, `SAC_ADDR_CTRL);
    // start without enable in the same write is dropped
    assign start_req = wr_ctrl && sfr_wdata_i[`SAC_CTRL_START] && sfr_wdata_i[`SAC_CTRL_ENABLE];
    assign finish    = busy && tick && (cyc_q == LAST_CYC);

    // ****************************************
    // converter clock
    // ****************************************
    // divider only runs while busy, so each conversion starts on a fresh count
    sac_clk_div #(
        .DW(DW)
    ) u_div (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .run_i          (busy),
        .divider_value_i(div_q),
        .tick_o         (tick)
    );

    // ****************************************
    // conversion sequencer
    // ****************************************
    // freeze is latched only while idle, so a busy write cannot arm it
    always @* begin
        st_d     = st_q;
        cyc_d    = cyc_q;
        freeze_d = freeze_q;
        case (st_q)
            ST_IDLE: begin
                cyc_d = 4'h0;
                if (wr_ctrl) begin
                    freeze_d = sfr_wdata_i[`SAC_CTRL_FREEZE];
                end
                if (start_req) begin
                    st_d = ST_CONV;
                end
            end
            // a start write while busy is ignored
            ST_CONV: begin
                // eleven converter clocks
                // counts converter ticks, not peripheral clocks
                if (tick) begin
                    cyc_d = cyc_q + 4'h1;
                end
                if (finish) begin
                    st_d     = ST_IDLE;
                    cyc_d    = 4'h0;
                    freeze_d = 1'b0;
                end
            end
            default: begin
                st_d     = ST_IDLE;
                cyc_d    = 4'h0;
                freeze_d = 1'b0;
            end
        endcase
    end

    // ****************************************
    // software visible fields
    // ****************************************
    always @* begin
        enable_d = enable_q;
        chsel_d  = chsel_q;
        div_d    = div_q;
        done_d   = done_q;
        res_d    = res_q;
        if (wr_div) begin
            div_d = sfr_wdata_i[DW-1:0];
        end
        // writes to the result bytes have no decode and are dropped
        if (wr_ctrl) begin
            enable_d = sfr_wdata_i[`SAC_CTRL_ENABLE];
            // channel and enable stay writable while busy
            chsel_d  = sfr_wdata_i[`SAC_CTRL_CHSEL];
            if (!sfr_wdata_i[`SAC_CTRL_DONE]) begin
                done_d = 1'b0;
            end
        end
        if (finish) begin
            done_d = 1'b1;
            res_d  = afe_result_i;
        end
    end

    // ****************************************
    // state and field registers
    // ****************************************
    // synchronous reset restores every field
    always @(posedge clk_i) begin
        if (rst_i) begin
            st_q     <= ST_IDLE;
            cyc_q    <= 4'h0;
            freeze_q <= CTRL_RST[`SAC_CTRL_FREEZE];
            enable_q <= CTRL_RST[`SAC_CTRL_ENABLE];
            done_q   <= CTRL_RST[`SAC_CTRL_DONE];
            chsel_q  <= CTRL_RST[`SAC_CTRL_CHSEL];
            div_q    <= DIV_RST[DW-1:0];
            res_q    <= {RES_W{1'b0}};
        end else begin
            st_q     <= st_d;
            cyc_q    <= cyc_d;
            freeze_q <= freeze_d;
            enable_q <= enable_d;
            done_q   <= done_d;
            chsel_q  <= chsel_d;
            div_q    <= div_d;
            res_q    <= res_d;
        end
    end

    // ****************************************
    // readback words
    // ****************************************
    // start reads set during conversion
    assign ctrl_rd     = ctrl_pack(freeze_q, enable_q, done_q, busy, chsel_q);
    assign div_rd      = {{(8-DW){1'b0}}, div_q};
    assign res_hi_byte = res_q[RES_W-1:RES_W-HI_W];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_lo
            if (gi < LO_W) begin : g_bit
                assign res_lo_byte[gi] = res_q[gi];
            end else begin : g_zero
                assign res_lo_byte[gi] = 1'b0;
            end
        end
    endgenerate

    // ****************************************
    // read mux
    // ****************************************
    // read strobe unused: data follows the address every cycle
    always @* begin
        // unmapped addresses read zero
        rdata_d = 8'h00;
        if (addr_hit(sfr_addr_i, `SAC_ADDR_CTRL)) begin
            rdata_d = ctrl_rd;
        end else if (addr_hit(sfr_addr_i, `SAC_ADDR_DIV)) begin
            rdata_d = div_rd;
        end else if (addr_hit(sfr_addr_i, `SAC_ADDR_RES_LO)) begin
            rdata_d = res_lo_byte;
        end else if (addr_hit(sfr_addr_i, `SAC_ADDR_RES_HI)) begin
            rdata_d = res_hi_byte;
        end
    end

    // ****************************************
    // analog and core side next values
    // ****************************************
    always @* begin
        power_d      = enable_q;
        sel_first_d  = chsel_q;
        sample_d     = busy;
        cpu_freeze_d = busy && freeze_q && !finish;
        // pending irqs stay in the core
        irq_d        = irq_en_i && (done_q || finish);
    end

    // ****************************************
    // registered outputs
    // ****************************************
    // every top output leaves from a flip-flop
    always @(posedge clk_i) begin
        if (rst_i) begin
            sfr_rdata_o     <= 8'h00;
            afe_power_o     <= 1'b0;
            afe_sel_first_o <= 1'b0;
            afe_sample_o    <= 1'b0;
            cpu_freeze_o    <= 1'b0;
            irq_o           <= 1'b0;
        end else begin
            sfr_rdata_o     <= rdata_d;
            afe_power_o     <= power_d;
            afe_sel_first_o <= sel_first_d;
            afe_sample_o    <= sample_d;
            cpu_freeze_o    <= cpu_freeze_d;
            irq_o           <= irq_d;
        end
    end
endmodule // sac_conv_ctrl

// ### sac_afe_model.sv
`timescale 1ns/100ps
module sac_afe_model (
    input  wire       clk_i,
    input  wire       sample_i,
    input  wire       sel_first_i,
    input  wire [9:0] first_i,
    input  wire [9:0] second_i,
    output reg  [9:0] result_o
);
    initial result_o = 10'h000;
    // idle output toggles so a stale value is never read as valid
    always @(posedge clk_i) result_o <= sample_i ? (sel_first_i ? first_i : second_i) : ~result_o;
endmodule // sac_afe_model

// ### sac_conv_ctrl_sva.sv
`timescale 1ns/100ps
module sac_conv_ctrl_sva (
    input wire       clk_i,
    input wire       rst_i,
    input wire [7:0] sfr_addr_i,
    input wire       sfr_wr_i,
    input wire [7:0] sfr_wdata_i,
    input wire [7:0] sfr_rdata_o,
    input wire       irq_en_i,
    input wire       afe_sel_first_o,
    input wire       afe_sample_o,
    input wire       cpu_freeze_o,
    input wire       irq_o
);
    reg [8:0] run_q;
    always @(posedge clk_i) run_q <= (rst_i || !afe_sample_o) ? 9'h000 : run_q + 9'h001;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence ctl_wr;
        sfr_wr_i && sfr_addr_i == 8'hf3;
    endsequence
    sequence go_wr;
        sfr_wr_i && sfr_addr_i == 8'hf3 && sfr_wdata_i[6:5] == 2'h3 && sfr_wdata_i[3] && !afe_sample_o;
    endsequence
    AST_FRZ_ON: assert property (go_wr |-> ##[1:3] cpu_freeze_o)
        else $error("freeze not raised");
    AST_FRZ_OFF: assert property ($fell(afe_sample_o) |-> ##[0:2] !cpu_freeze_o)
        else $error("freeze not dropped");
    AST_RUN: assert property ($fell(afe_sample_o) |-> run_q >= 9'h00b)
        else $error("conversion too short");
    AST_SEL: assert property (ctl_wr |=> ##1 afe_sel_first_o == $past(sfr_wdata_i[0], 2))
        else $error("wrong channel");
    AST_IRQ: assert property (irq_o |-> $past(irq_en_i))
        else $error("irq while disabled");
    AST_LO: assert property ($past(sfr_addr_i) == 8'hf4 |-> sfr_rdata_o[7:2] == 6'h00)
        else $error("low byte upper bits set");
    AST_RSVD: assert property ($past(sfr_addr_i) == 8'hf3 |-> (sfr_rdata_o & 8'h86) == 8'h00)
        else $error("reserved bits set");
    AST_UNMAP: assert property ($past(sfr_addr_i) < 8'hf2 || $past(sfr_addr_i) > 8'hf5 |-> sfr_rdata_o == 8'h00)
        else $error("unmapped read nonzero");
endmodule // sac_conv_ctrl_sva
bind sac_conv_ctrl sac_conv_ctrl_sva chk (.clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o,
    .irq_en_i, .afe_sel_first_o, .afe_sample_o, .cpu_freeze_o, .irq_o);

// ### sac_conv_ctrl_tb.sv
`timescale 1ns/100ps
module sac_conv_ctrl_tb;
    logic       clk_i = 0, rst_i = 1, wr = 0, irq_en = 0;
    logic [7:0] addr = 0, wdata = 0, ctl, fz;
    logic [9:0] v1 = 0, v2 = 0, ev = 0, pv = 0, eq[$], sq[$];
    wire  [9:0] res;
    wire  [7:0] rdata;
    wire        pwr, sel1, smp, frz, irq;
    int         failures = 0, num_checks = 0, cyc = 0, n, cnt;
    string      nq[$];
    event       got;
    sac_conv_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata),
        .sfr_rd_i(1'b1), .sfr_rdata_o(rdata), .irq_en_i(irq_en), .afe_result_i(res), .afe_power_o(pwr),
        .afe_sel_first_o(sel1), .afe_sample_o(smp), .cpu_freeze_o(frz), .irq_o(irq));
    sac_afe_model afe (.clk_i(clk_i), .sample_i(smp), .sel_first_i(sel1), .first_i(v1), .second_i(v2),
        .result_o(res));
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (++cyc == 5000) begin failures++; results; end
    always @(got) while (sq.size() > 0) chk(nq.pop_front(), sq.pop_front(), eq.pop_front());
    task chk(input string nm, input logic [9:0] s, input logic [9:0] e);
        num_checks++;
        if (s !== e) begin failures++; $display("unexpected %s: expected %h seen %h", nm, e, s); end
    endtask
    task obs(input string nm, input logic [9:0] s, input logic [9:0] e);
        nq.push_back(nm);
        sq.push_back(s);
        eq.push_back(e);
        ->got;
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i) {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge clk_i) wr = 0;
    endtask
    task rd_reg(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i) addr = a;
        @(negedge clk_i) obs(nm, {2'h0, rdata}, {2'h0, e});
    endtask
    task results;
        @(negedge clk_i);
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        void'($urandom(68381));
        repeat (6) @(negedge clk_i);
        rst_i = 0;
        for (int a = 242; a < 246; a++) rd_reg("reset", 8'(a), 8'h00);
        rd_reg("unmapped", 8'h80, 8'h00);
        wr_reg(8'hf2, 8'hff);
        rd_reg("divider", 8'hf2, 8'h1f);
        wr_reg(8'hf5, 8'hff);
        rd_reg("read only", 8'hf5, 8'h00);
        wr_reg(8'hf3, 8'h8f);
        rd_reg("control", 8'hf3, 8'h01);
        obs("channel", {9'h0, sel1}, 10'h1);
        for (int i = 0; i < 3; i++) begin
            n = (i == 2) ? 32 : 2 * i + 1;
            pv = ev;
            v1 = 10'($urandom);
            v2 = 10'($urandom);
            ctl = {7'h00, 1'($urandom)};
            fz = (i == 1) ? 8'h00 : 8'h40;
            irq_en = (i != 1);
            ev = ctl[0] ? v1 : v2;
            wr_reg(8'hf2, 8'(n % 32));
            wr_reg(8'hf3, 8'h20 | ctl);
            repeat (4) @(negedge clk_i);
            // enable and start in one write, with freeze set except when i is 1
            wr_reg(8'hf3, 8'h28 | fz | ctl);
            rd_reg("busy", 8'hf3, 8'h28 | fz | ctl);
            obs("freeze", {9'h0, frz}, {9'h0, fz[6]});
            obs("power", {9'h0, pwr}, 10'h1);
            rd_reg("prior", 8'hf5, pv[9:2]);
            cnt = 4;
            while (smp && cnt < 400) begin @(negedge clk_i); cnt++; end
            obs("duration", 10'(cnt >= 11 * n - 1 && cnt <= 11 * n + 3), 10'h1);
            rd_reg("done", 8'hf3, 8'h30 | ctl);
            obs("irq", {9'h0, irq}, {9'h0, irq_en});
            rd_reg("high", 8'hf5, ev[9:2]);
            rd_reg("low", 8'hf4, {6'h00, ev[1:0]});
            wr_reg(8'hf3, 8'h20 | ctl);
            @(negedge clk_i);
            obs("irq clear", {9'h0, irq}, 10'h0);
            rd_reg("held", 8'hf5, ev[9:2]);
        end
        wr_reg(8'hf3, 8'h00);
        @(negedge clk_i);
        obs("standby", {9'h0, pwr}, 10'h0);
        results;
    end
endmodule // sac_conv_ctrl_tb
